// >>> rtl/dbg_status_ctrl.sv
// Upper field group of the external debug status and control register
//
// Operation
// - Override set ignores EL1/EL2 trace filters
// - Override disregarded when secure/realm trace blocked
// - Cold reset clears override and receive-full
// - Transmit-full, overrun, underrun read-only, reset zero
// - Receive-full, overrun, underrun ignore writes
// - Instruction overrun clears on Debug entry
// - Instruction flags unknown unless halted
// - Progress sets advance flag; debugger clears
// - Advance flag read-only, warm reset unknown
// - Four-state variant masks enabled security states
// - Masking covers virtual and error interrupts
// - Field effectively zero without non-secure debug
// - Only bit 22 functional, 23 reads zero
// - Cold reset clears interrupt-disable field
// - Two-state variant masks non-secure and secure
// - OS lock lets system software reach fields
// - One 32-bit register holds all fields
`timescale 1ns/10ps
`include "dbg_scr_regs.svh"
module dbg_status_ctrl #(
    parameter bit TRF_IMPL    = 1'b1,
    parameter bit FOUR_STATES = 1'b1,
    parameter int PADV_PERIOD = `PADV_PERIOD_CYC
) (
    // Clock and reset (rst is the cold reset)
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     warm_rst,
    // Avalon-MM slave
    input  wire logic [3:0]               avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic [31:0]                   avs_readdata,
    output logic                          avs_waitrequest,
    output logic [1:0]                    avs_response,
    // Processing element state
    input  wire logic                     halted,
    input  wire logic                     os_lock_status,
    input  wire dbg_scr_pkg::xfer_flags_t xfer,
    // System-side indirect access while the OS lock is set
    input  wire logic                     sys_wr,
    input  wire logic [31:0]              sys_wdata,
    output logic [31:0]                   sys_rdata,
    // Effects on the processing element
    output logic                          el1_trace_filter_ctrl_ignore,
    output logic                          el2_trace_filter_ctrl_ignore,
    output dbg_scr_pkg::irq_mask_t        irq_mask
);
    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // One wait state per access keeps read data registered
    logic        ack_r;
    logic        req;
    logic        wr_acc;
    logic        rd_acc;

    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_r;
    assign wr_acc          = avs_write && ack_r;
    assign rd_acc          = avs_read && !ack_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction

    // ****************************************************************
    // Stored control fields
    // ****************************************************************
    logic                 tfo_r;
    logic                 intd_r;
    dbg_scr_pkg::auth_t   auth_r;
    logic                 wr_main;
    logic                 wr_auth;

    assign wr_main = wr_acc && hit(avs_address, `OFS_STATUS_CTRL) && avs_byteenable[3];
    assign wr_auth = wr_acc && hit(avs_address, `OFS_AUTH_CTRL) && avs_byteenable[0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tfo_r <= 1'b0;
        end else if (!TRF_IMPL) begin
            tfo_r <= 1'b0;
        end else if (os_lock_status && sys_wr) begin
            tfo_r <= sys_wdata[`BIT_TFO];
        end else if (wr_main) begin
            tfo_r <= avs_writedata[`BIT_TFO];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intd_r <= 1'b0;
        end else if (os_lock_status && sys_wr) begin
            intd_r <= sys_wdata[`BIT_INTD_LO];
        end else if (avs_byteenable[2] && wr_acc && hit(avs_address, `OFS_STATUS_CTRL)) begin
            intd_r <= avs_writedata[`BIT_INTD_LO];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            auth_r <= dbg_scr_pkg::auth_t'(`RST_AUTH_CTRL);
        end else if (wr_auth) begin
            auth_r <= dbg_scr_pkg::auth_t'(avs_writedata[7:0]);
        end
    end

    // ****************************************************************
    // Transfer flags
    // ****************************************************************
    // flags follow hardware only, bus writes ignored
    logic rxf_r;
    logic txf_r;
    logic rxo_r;
    logic txu_r;
    logic ito_r;
    logic ite_r;
    logic halted_d_r;

    // transmit-full, overrun, underrun clear on cold reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxf_r <= 1'b0;
            txf_r <= 1'b0;
            rxo_r <= 1'b0;
            txu_r <= 1'b0;
        end else begin
            rxf_r <= xfer.rx_full;
            txf_r <= xfer.tx_full;
            rxo_r <= xfer.rx_overrun;
            txu_r <= xfer.tx_underrun;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halted_d_r <= 1'b0;
        end else begin
            halted_d_r <= halted;
        end
    end

    // instruction overrun clears on Debug entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ito_r <= 1'b0;
            ite_r <= 1'b0;
        end else begin
            ito_r <= (halted && !halted_d_r) ? 1'b0 : xfer.itr_overrun;
            ite_r <= xfer.itr_empty;
        end
    end

    // ****************************************************************
    // Pipeline advance
    // ****************************************************************
    logic padv_r;
    logic padv_tick_w;
    logic clr_padv;

    assign clr_padv = wr_acc && hit(avs_address, `OFS_RUN_CTRL) && avs_byteenable[0]
                      && avs_writedata[`BIT_CLR_PADV];

    padv_tick #(
        .PERIOD (PADV_PERIOD)
    ) u_tick (
        .clk     (clk),
        .rst     (rst),
        .running (!halted),
        .tick    (padv_tick_w)
    );

    // progress sets, write-one clears, set wins
    // warm reset value is left unknown; chosen as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            padv_r <= 1'b0;
        end else if (padv_tick_w) begin
            padv_r <= 1'b1;
        end else if (warm_rst || clr_padv) begin
            padv_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Effective controls
    // ****************************************************************
    logic tfo_eff;
    logic intd_eff;

    // override disregarded when trace is blocked
    assign tfo_eff = tfo_r
                     && !(!auth_r.secure_noninv && auth_r.secure_trace_enable)
                     && !(FOUR_STATES && !auth_r.realm_noninv && auth_r.realm_trace_enable);

    // override ignores EL1 and EL2 filters
    assign el1_trace_filter_ctrl_ignore = tfo_eff;
    assign el2_trace_filter_ctrl_ignore = tfo_eff;

    // effective zero without non-secure invasive debug
    assign intd_eff = intd_r && auth_r.ns_inv;

    // four-state variant masks each enabled state
    // two-state variant masks non-secure and secure
    // virtual and error interrupts masked too
    always_comb begin
        irq_mask           = '0;
        irq_mask.nonsecure = intd_eff;
        irq_mask.secure    = intd_eff && auth_r.secure_inv;
        irq_mask.root      = FOUR_STATES && intd_eff && auth_r.root_inv;
        irq_mask.realm     = FOUR_STATES && intd_eff && auth_r.realm_inv;
        irq_mask.virt      = intd_eff;
        irq_mask.serror    = intd_eff;
    end

    // ****************************************************************
    // Read view
    // ****************************************************************
    // single 32-bit word holds all fields
    logic [31:0] scr_word;

    // instruction flags unknown when running; shown as zero
    always_comb begin
        scr_word                = `RST_STATUS_CTRL;
        scr_word[`BIT_TFO]      = TRF_IMPL ? tfo_r : 1'b0;
        scr_word[`BIT_RXF]      = rxf_r;
        scr_word[`BIT_TXF]      = txf_r;
        scr_word[`BIT_ITO]      = halted ? ito_r : 1'b0;
        scr_word[`BIT_RXO]      = rxo_r;
        scr_word[`BIT_TXU]      = txu_r;
        scr_word[`BIT_PADV]     = padv_r;
        scr_word[`BIT_ITE]      = halted ? ite_r : 1'b0;
        scr_word[`BIT_INTD_HI]  = 1'b0;
        scr_word[`BIT_INTD_LO]  = intd_r;
    end

    // system view of override and field under lock
    always_comb begin
        sys_rdata = 32'h0000_0000;
        if (os_lock_status) begin
            sys_rdata[`BIT_TFO]     = scr_word[`BIT_TFO];
            sys_rdata[`BIT_INTD_LO] = intd_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else if (rd_acc) begin
            avs_response <= 2'b00;
            case (avs_address)
                `OFS_STATUS_CTRL: avs_readdata <= scr_word;
                `OFS_SYS_STATUS:  avs_readdata <= sys_rdata;
                `OFS_AUTH_CTRL:   avs_readdata <= {24'h00_0000, auth_r};
                `OFS_RUN_CTRL:    avs_readdata <= 32'h0000_0000;
                default: begin
                    avs_readdata <= 32'h0000_0000;
                    avs_response <= 2'b10;
                end
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_ito_entry_clear: assert property (
        @(posedge clk) disable iff (rst) (halted && !halted_d_r) |=> !ito_r)
        else $error("instruction overrun not cleared on debug entry");

    a_padv_set_wins: assert property (
        @(posedge clk) disable iff (rst) padv_tick_w |=> padv_r)
        else $error("advance flag missed a progress tick");

    a_padv_clear: assert property (
        @(posedge clk) disable iff (rst) (clr_padv && !padv_tick_w && !warm_rst) |=> !padv_r)
        else $error("advance flag not cleared");

    a_intd_bit23: assert property (
        @(posedge clk) disable iff (rst) !scr_word[`BIT_INTD_HI])
        else $error("bit 23 not zero");

    a_intd_eff_zero: assert property (
        @(posedge clk) disable iff (rst) !auth_r.ns_inv |-> (irq_mask == '0))
        else $error("mask active without non-secure debug");

    a_mask_virt: assert property (
        @(posedge clk) disable iff (rst) irq_mask.nonsecure |-> (irq_mask.virt && irq_mask.serror))
        else $error("virtual or error interrupts not masked");

    a_tfo_block: assert property (
        @(posedge clk) disable iff (rst)
        (!auth_r.secure_noninv && auth_r.secure_trace_enable) |-> !el1_trace_filter_ctrl_ignore)
        else $error("override honoured while secure trace blocked");

    a_tfo_follow: assert property (
        @(posedge clk) disable iff (rst)
        (wr_main && TRF_IMPL && !(os_lock_status && sys_wr)) |=> tfo_r == $past(avs_writedata[31]))
        else $error("override write lost");

    a_ro_flags: assert property (
        @(posedge clk) disable iff (rst) ##1 rxf_r == $past(xfer.rx_full))
        else $error("receive full does not follow hardware");

    a_ite_hidden: assert property (
        @(posedge clk) disable iff (rst) !halted |-> !scr_word[`BIT_ITE] && !scr_word[`BIT_ITO])
        else $error("instruction flags visible while running");
endmodule

// >>> common/dbg_scr_regs.svh
// Offsets, field positions, reset values and timing counts of the debug status block
`ifndef DBG_SCR_REGS_SVH
`define DBG_SCR_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses, word aligned)
// ****************************************************************
`define OFS_STATUS_CTRL      4'h0
`define OFS_RUN_CTRL         4'h4
`define OFS_SYS_STATUS       4'h8
`define OFS_AUTH_CTRL        4'hC

// ****************************************************************
// Field positions in the status and control word
// ****************************************************************
`define BIT_TFO              31
`define BIT_RXF              30
`define BIT_TXF              29
`define BIT_ITO              28
`define BIT_RXO              27
`define BIT_TXU              26
`define BIT_PADV             25
`define BIT_ITE              24
`define BIT_INTD_HI          23
`define BIT_INTD_LO          22

// Run control: write one to clear the progress flag
`define BIT_CLR_PADV         3

// Authentication / environment word positions
`define AUTH_NS_INV          0
`define AUTH_S_INV           1
`define AUTH_ROOT_INV        2
`define AUTH_REALM_INV       3
`define AUTH_S_NONINV        4
`define AUTH_REALM_NONINV    5
`define AUTH_STE             6
`define AUTH_RLTE            7

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RST_STATUS_CTRL      32'h0000_0000
`define RST_AUTH_CTRL        8'h00
`define PADV_PERIOD_NS       100
`define CLK_PERIOD_NS        25
`define PADV_PERIOD_CYC      ((`PADV_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> common/dbg_scr_pkg.sv
// Types shared by the debug status and control block
package dbg_scr_pkg;

    typedef enum logic [1:0] {
        INTD_NONE,
        INTD_MASK,
        INTD_RSVD2,
        INTD_RSVD3
    } intd_mode_t;

    // Transfer-register event inputs from the data channel
    typedef struct packed {
        logic rx_full;
        logic tx_full;
        logic rx_overrun;
        logic tx_underrun;
        logic itr_overrun;
        logic itr_empty;
    } xfer_flags_t;

    // Interrupt mask outputs per security state, physical plus virtual and error
    typedef struct packed {
        logic nonsecure;
        logic secure;
        logic root;
        logic realm;
        logic virt;
        logic serror;
    } irq_mask_t;

    // Authentication inputs
    typedef struct packed {
        logic realm_trace_enable;
        logic secure_trace_enable;
        logic realm_noninv;
        logic secure_noninv;
        logic realm_inv;
        logic root_inv;
        logic secure_inv;
        logic ns_inv;
    } auth_t;

endpackage

// >>> rtl/padv_tick.sv
// Periodic progress tick generator for the pipeline-advance flag
`timescale 1ns/10ps
module padv_tick #(
    parameter int PERIOD = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic running,
    output logic      tick
);
    logic [15:0] cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 16'h0000;
        end else if (!running) begin
            cnt_r <= 16'h0000;
        end else if (cnt_r == 16'(PERIOD - 1)) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    assign tick = running && (cnt_r == 16'(PERIOD - 1));
endmodule

// >>> tb/dbg_master.sv
// Avalon-MM master model standing in for the external debugger
`timescale 1ns/10ps
module dbg_master (
    // Clock
    input  wire logic        clk,
    // Avalon-MM master side
    output logic [3:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    input  wire logic [1:0]  avs_response
);
    initial begin
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'h0;
    end

    // Waitrequest is looked at on each rising edge, before the slave's
    // registers move; no latency is assumed, only the bench timeout ends it
    task automatic wait_ack();
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        wait_ack();
        avs_write      <= 1'b0;
    endtask

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        avs_address    <= a;
        avs_byteenable <= 4'hf;
        avs_read       <= 1'b1;
        wait_ack();
        d = avs_readdata;
        r = avs_response;
        avs_read       <= 1'b0;
    endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench of the debug status and control block
`timescale 1ns/10ps
module tb_top;
    logic                      clk;
    logic                      rst;
    logic                      warm_rst;
    logic [3:0]                avs_address;
    logic                      avs_read;
    logic                      avs_write;
    logic [31:0]               avs_writedata;
    logic [3:0]                avs_byteenable;
    logic [31:0]               avs_readdata;
    logic                      avs_waitrequest;
    logic [1:0]                avs_response;
    logic                      halted;
    logic                      os_lock_status;
    dbg_scr_pkg::xfer_flags_t  xfer;
    logic                      sys_wr;
    logic [31:0]               sys_wdata;
    logic [31:0]               sys_rdata;
    logic                      el1_ign;
    logic                      el2_ign;
    dbg_scr_pkg::irq_mask_t    irq_mask;
    logic [31:0]               sys_rdata2;
    logic                      el1_ign2;
    dbg_scr_pkg::irq_mask_t    irq_mask2;
    logic [31:0]               rd;
    logic [1:0]                rr;
    int                        n_errors;
    int                        checked;
    logic [7:0]                auth_tab [4];
    logic                      ign_tab [4];

    dbg_status_ctrl #(.PADV_PERIOD(4)) u_dbg_status_ctrl (
        .clk(clk), .rst(rst), .warm_rst(warm_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .halted(halted), .os_lock_status(os_lock_status),
        .xfer(xfer), .sys_wr(sys_wr), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata),
        .el1_trace_filter_ctrl_ignore(el1_ign), .el2_trace_filter_ctrl_ignore(el2_ign),
        .irq_mask(irq_mask)
    );

    // Two-state variant without the trace filter, fed the same stimulus
    dbg_status_ctrl #(
        .TRF_IMPL    (1'b0),
        .FOUR_STATES (1'b0),
        .PADV_PERIOD (4)
    ) u_dbg_status_ctrl_two_state (
        .clk(clk), .rst(rst), .warm_rst(warm_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(), .avs_waitrequest(), .avs_response(),
        .halted(halted), .os_lock_status(os_lock_status),
        .xfer(xfer), .sys_wr(sys_wr), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata2),
        .el1_trace_filter_ctrl_ignore(el1_ign2), .el2_trace_filter_ctrl_ignore(),
        .irq_mask(irq_mask2)
    );

    dbg_master u_dbg_master (
        .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic finish_test();
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole sequence needs well under a thousand cycles
    initial begin
        #(25 * 5000);
        n_errors++;
        finish_test();
    end

    initial begin
        n_errors = 0;
        checked = 0;
        rst = 1'b1;
        warm_rst = 1'b0;
        halted = 1'b1;
        os_lock_status = 1'b0;
        xfer = '0;
        sys_wr = 1'b0;
        sys_wdata = 32'h0000_0000;
        // Noninvasive off with trace enable set blocks the override; otherwise it applies
        auth_tab = '{8'h40, 8'h50, 8'h80, 8'hA0};
        ign_tab = '{1'b0, 1'b1, 1'b0, 1'b1};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // ************************************************************
        // Cold reset values
        // ************************************************************
        u_dbg_master.bus_read(4'h0, rd, rr);
        chk_word("status after reset", 32'h0000_0000, rd);
        chk_resp("status response", 2'b00, rr);
        u_dbg_master.bus_write(4'h0, 32'hFFFF_FFFF, 4'h3);
        u_dbg_master.bus_read(4'h0, rd, rr);
        chk_word("status lanes off", 32'h0000_0000, rd);
        // ************************************************************
        // Writable bits only; flags and bit 23 ignore writes
        // ************************************************************
        u_dbg_master.bus_write(4'h0, 32'hFFFF_FFFF, 4'hf);
        u_dbg_master.bus_read(4'h0, rd, rr);
        chk_word("status all ones", 32'h8040_0000, rd);
        @(posedge clk);
        xfer <= '1;
        u_dbg_master.bus_read(4'h0, rd, rr);
        chk_word("flags halted", 32'hFD40_0000, rd);
        // ************************************************************
        // Running: instruction flags read zero, progress flag sets
        // ************************************************************
        @(posedge clk);
        halted <= 1'b0;
        repeat (12) @(posedge clk);
        u_dbg_master.bus_read(4'h0, rd, rr);
        chk_word("flags running", 32'hEE40_0000, rd);
        u_dbg_master.bus_write(4'hC, 32'h0000_000B, 4'hf);
        @(posedge clk);
        chk_word("irq mask enabled", 32'h0000_0037, 32'(irq_mask));
        chk_word("irq mask two-state", 32'h0000_0033, 32'(irq_mask2));
        chk_word("el1 ignore no filter", 32'h0, 32'(el1_ign2));
        chk_word("el1 ignore", 32'h1, 32'(el1_ign));
        chk_word("el2 ignore", 32'h1, 32'(el2_ign));
        for (int i = 0; i < 4; i++) begin
            u_dbg_master.bus_write(4'hC, {24'h00_0000, auth_tab[i]}, 4'hf);
            @(posedge clk);
            chk_word("el1 ignore gated", 32'(ign_tab[i]), 32'(el1_ign));
        end
        u_dbg_master.bus_write(4'hC, 32'h0000_000E, 4'hf);
        @(posedge clk);
        chk_word("irq mask no ns debug", 32'h0000_0000, 32'(irq_mask));
        // ************************************************************
        // Halt, then the debugger clears the progress flag
        // ************************************************************
        @(posedge clk);
        halted <= 1'b1;
        xfer <= '0;
        repeat (2) @(posedge clk);
        u_dbg_master.bus_write(4'h4, 32'h0000_0008, 4'hf);
        u_dbg_master.bus_read(4'h0, rd, rr);
        chk_word("advance cleared", 32'h8040_0000, rd);
        // ************************************************************
        // System-side access under the OS lock
        // ************************************************************
        @(posedge clk);
        os_lock_status <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk_word("system view", 32'h8040_0000, sys_rdata);
        chk_word("system view two-state", 32'h0040_0000, sys_rdata2);
        u_dbg_master.bus_read(4'h8, rd, rr);
        chk_word("system view bus", 32'h8040_0000, rd);
        @(posedge clk);
        sys_wr <= 1'b1;
        @(posedge clk);
        sys_wr <= 1'b0;
        u_dbg_master.bus_read(4'h0, rd, rr);
        chk_word("status after system write", 32'h0000_0000, rd);
        u_dbg_master.bus_write(4'hC, 32'h0000_000F, 4'hf);
        @(posedge clk);
        os_lock_status <= 1'b0;
        halted <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk_word("system view unlocked", 32'h0000_0000, sys_rdata);
        chk_word("irq mask field clear", 32'h0000_0000, 32'(irq_mask));
        // ************************************************************
        // Progress sets the advance flag again; warm reset drops it
        // ************************************************************
        repeat (6) @(posedge clk);
        halted <= 1'b1;
        repeat (2) @(posedge clk);
        u_dbg_master.bus_read(4'h0, rd, rr);
        chk_word("advance set again", 32'h0200_0000, rd);
        @(posedge clk);
        warm_rst <= 1'b1;
        @(posedge clk);
        warm_rst <= 1'b0;
        u_dbg_master.bus_read(4'h0, rd, rr);
        chk_word("advance after warm reset", 32'h0000_0000, rd);
        // ************************************************************
        // Unmapped address answers with an error
        // ************************************************************
        u_dbg_master.bus_read(4'h1, rd, rr);
        chk_word("unmapped data", 32'h0000_0000, rd);
        chk_resp("unmapped response", 2'b10, rr);
        finish_test();
    end
endmodule
